// ---- core/anps_pkg.sv ----
// Constants shared by the partner-status register group of the negotiation block.
// Assumes 5-bit register addresses and 16-bit register words on the management link.
package anps_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [4:0]  REG_ABIL        = 5'h05;
   localparam logic [4:0]  REG_EXP         = 5'h06;
   localparam logic [4:0]  REG_SETUP       = 5'h10;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [15:0] ABIL_RESET      = 16'h0080;
   localparam logic [15:0] ABIL_RSVD_MASK  = 16'h1800;
   localparam int          ABIL_TX_BIT     = 7;
   localparam int          ABIL_10_BIT     = 5;
   localparam logic [2:0]  SETUP_RESET     = 3'h0;
   localparam int          SETUP_LED_BIT   = 11;
   localparam int          SETUP_FAST_BIT  = 10;
   localparam int          SETUP_LOOP_BIT  = 9;

   // ----------------------------------------------------------------
   // Management frame fields
   // ----------------------------------------------------------------
   localparam logic [5:0]  PREAMBLE_BITS   = 6'h20;
   localparam logic [1:0]  OP_READ         = 2'h2;
   localparam logic [1:0]  OP_WRITE        = 2'h1;
   localparam logic [3:0]  HDR_LAST        = 4'hB;
   localparam logic [3:0]  DATA_LAST       = 4'hF;

endpackage : anps_pkg

// ---- core/anps_sync.sv ----
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/1ps
module anps_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule : anps_sync

// ---- core/anps_sticky.sv ----
// Bank of sticky status flags, set by hardware events and optionally cleared.
// Assumes set and clear are single-cycle terms on the same clock.
`timescale 1ns/1ps
module anps_sticky #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_b,
   // Events
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] flags
);

   logic [W-1:0] flags_q;

   // An event landing in the clearing cycle is kept: set wins over clear.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         flags_q <= '0;
      else
         flags_q <= set | (flags_q & ~clr);
   end

   assign flags = flags_q;

endmodule : anps_sticky

// ---- core/anps_regs.sv ----
// Partner ability, negotiation expansion and setup registers with their management slave.
// Assumes negotiation-engine inputs are on this clock; mdc, mdio and the
// address straps are asynchronous pins.
`timescale 1ns/1ps

// Functional notes
// - Capture partner ability word from negotiation; management reads it only.
// - Later next pages may replace the ability word after negotiation completes.
// - Ability bit 15 shows partner next-page flag; resets to 0.
// - Ability bit 14 shows partner acknowledge; resets to 0.
// - Ability bit 13 shows partner remote fault; resets to 0.
// - Ability bit 10 shows partner pause; bits 12 to 11 reserved.
// - Ability bits 9, 8, 6 show T4, fast and slow full duplex.
// - Ability bit 7 resets to 1, set by 100 Mb/s parallel detection.
// - Ability bit 5 resets to 0, set by 10 Mb/s parallel detection.
// - Ability bits 4 to 0 hold partner selector, reset zero.
// - Expansion bits 15 to 5 always read zero.
// - Expansion bit 4 sticks at 1 after a multiple link fault.
// - Expansion bit 3 shows partner next-page capability.
// - Expansion bit 2 shows local next-page capability, read-only.
// - Expansion bit 1 sets on new page, clears when ability is read.
// - Expansion bit 0 shows partner negotiation capability.
// - Setup bit 11 makes the fourth LED show link pulses.
// - Setup bit 10 speeds up negotiation timers for test.
// - Setup bit 9 puts negotiation in loopback; bits 8 to 3 reserved.
// - Setup bit 2 reads 1 once ability detect was visited.
// - Setup bit 1 reads 1 once parallel detection fault was visited.
// - Setup bit 0 reads 1 once link status check was visited.
module anps_regs (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // Management pins
   input  wire logic        mdc,
   input  wire logic        mdioIn,
   output logic             mdioOut,
   output logic             mdioOe,
   input  wire logic [4:0]  phyAddr,
   // Negotiation engine events and levels
   input  wire logic        pageRxPulse,
   input  wire logic [15:0] pageWord,
   input  wire logic        parDet100Pulse,
   input  wire logic        parDet10Pulse,
   input  wire logic        mlfPulse,
   input  wire logic        partnerNpCapable,
   input  wire logic        localNpCapable,
   input  wire logic        partnerAnCapable,
   input  wire logic        abilityDetectPulse,
   input  wire logic        parallelFaultPulse,
   input  wire logic        linkCheckPulse,
   // Status LED
   input  wire logic        linkPulse,
   input  wire logic        ledNormal,
   output logic             fourthStatusLed,
   // Setup controls
   output logic             timerFastMode,
   output logic             autonegLoopback
);

   typedef enum logic [2:0] {S_IDLE, S_START, S_HDR, S_TA, S_DATA} anps_state_t;

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [6:0]  pinSync;
   logic        mdcS;
   logic        mdioS;
   logic [4:0]  addrS;
   logic        mdcPrev_q;
   logic        rise;

   anps_sync #(.W(7)) u_sync (
      .clock (clock),
      .rst_b (rst_b),
      .din   ({mdc, mdioIn, phyAddr}),
      .dout  (pinSync)
   );

   assign mdcS  = pinSync[6];
   assign mdioS = pinSync[5];
   assign addrS = pinSync[4:0];

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         mdcPrev_q <= 1'b0;
      else
         mdcPrev_q <= mdcS;
   end

   assign rise = mdcS & ~mdcPrev_q;

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [15:0] abil_q;
   logic [15:0] abil_d;
   logic [2:0]  setup_q;
   logic [4:0]  flags;
   logic [4:0]  flagSet;
   logic [4:0]  flagClr;
   logic        ledOut_q;

   // Sticky flags: 4 multiple link fault, 3 page received, 2..0 state history.
   anps_sticky #(.W(5)) u_flags (
      .clock (clock),
      .rst_b (rst_b),
      .set   (flagSet),
      .clr   (flagClr),
      .flags (flags)
   );

   function automatic logic [15:0] regRead(input logic [4:0] a);
      logic [15:0] v;
      unique case (a)
         anps_pkg::REG_ABIL:  v = abil_q;
         anps_pkg::REG_EXP:   v = {11'h000, flags[4], partnerNpCapable,
                             localNpCapable, flags[3], partnerAnCapable};
         anps_pkg::REG_SETUP: v = {4'h0, setup_q, 6'h00, flags[2:0]};
         default:             v = 16'h0000;
      endcase
      return v;
   endfunction : regRead

   // ----------------------------------------------------------------
   // Management frame engine
   // ----------------------------------------------------------------
   anps_state_t state_q;
   logic [3:0]  bitCnt_q;
   logic [5:0]  preCnt_q;
   logic        firstPending_q;
   logic [11:0] hdr_q;
   logic [11:0] hdrNext;
   logic [15:0] wrShift_q;
   logic        isWrite_q;
   logic        hit_q;
   logic [4:0]  regSel_q;
   logic        startOk;
   logic        hdrHit;
   logic        rdHit;
   logic        wrCommit;
   logic        rdCapture;

   assign hdrNext = {hdr_q[10:0], mdioS};

   // Only the first frame after reset needs the full preamble; later frames
   // need just the idle bit, which is what preamble suppression allows.
   assign startOk = firstPending_q ? (preCnt_q == anps_pkg::PREAMBLE_BITS)
                                   : (preCnt_q != 6'h00);
   assign hdrHit  = (hdrNext[9:5] == addrS) &&
                    ((hdrNext[4:0] == anps_pkg::REG_ABIL) ||
                     (hdrNext[4:0] == anps_pkg::REG_EXP) ||
                     (hdrNext[4:0] == anps_pkg::REG_SETUP));
   assign rdHit   = hit_q & ~isWrite_q;
   assign wrCommit = rise && (state_q == S_DATA) && (bitCnt_q == anps_pkg::DATA_LAST) &&
                     isWrite_q && hit_q && (regSel_q == anps_pkg::REG_SETUP);
   assign rdCapture = rise && (state_q == S_TA) && (bitCnt_q == 4'h1) && rdHit;

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state_q        <= S_IDLE;
         bitCnt_q       <= 4'h0;
         preCnt_q       <= 6'h00;
         firstPending_q <= 1'b1;
         hdr_q          <= 12'h000;
         wrShift_q      <= 16'h0000;
         isWrite_q      <= 1'b0;
         hit_q          <= 1'b0;
         regSel_q       <= 5'h00;
      end
      else if (rise)
      begin
         unique case (state_q)
            S_IDLE:
            begin
               if (!mdioS)
                  preCnt_q <= 6'h00;
               else if (preCnt_q != anps_pkg::PREAMBLE_BITS)
                  preCnt_q <= preCnt_q + 6'h01;
               if (!mdioS && startOk)
                  state_q <= S_START;
            end
            S_START:
               state_q <= mdioS ? S_HDR : S_IDLE;
            S_HDR:
            begin
               hdr_q    <= hdrNext;
               bitCnt_q <= bitCnt_q + 4'h1;
               if (bitCnt_q == anps_pkg::HDR_LAST)
               begin
                  firstPending_q <= 1'b0;
                  isWrite_q      <= (hdrNext[11:10] == anps_pkg::OP_WRITE);
                  hit_q          <= hdrHit && ((hdrNext[11:10] == anps_pkg::OP_WRITE) ||
                                               (hdrNext[11:10] == anps_pkg::OP_READ));
                  regSel_q       <= hdrNext[4:0];
                  bitCnt_q       <= 4'h0;
                  state_q        <= S_TA;
               end
            end
            S_TA:
            begin
               bitCnt_q <= (bitCnt_q == 4'h1) ? 4'h0 : bitCnt_q + 4'h1;
               if (bitCnt_q == 4'h1)
                  state_q <= S_DATA;
            end
            S_DATA:
            begin
               wrShift_q <= {wrShift_q[14:0], mdioS};
               bitCnt_q  <= bitCnt_q + 4'h1;
               if (bitCnt_q == anps_pkg::DATA_LAST)
               begin
                  preCnt_q <= 6'h00;
                  state_q  <= S_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data drive
   // ----------------------------------------------------------------
   logic [15:0] rdShift_q;
   logic        mdioOut_q;
   logic        mdioOe_q;

   // Data changes right after the rising edge, so the controller sees a full
   // period of settling before its own sampling edge.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         rdShift_q <= 16'h0000;
         mdioOut_q <= 1'b0;
         mdioOe_q  <= 1'b0;
      end
      else if (rise)
      begin
         if ((state_q == S_TA) && (bitCnt_q == 4'h0) && rdHit)
            {mdioOe_q, mdioOut_q} <= 2'h2;
         else if (rdCapture)
            {mdioOut_q, rdShift_q} <= {regRead(regSel_q), 1'b0};
         else if ((state_q == S_DATA) && mdioOe_q)
         begin
            if (bitCnt_q == anps_pkg::DATA_LAST)
               mdioOe_q <= 1'b0;
            else
               {mdioOut_q, rdShift_q} <= {rdShift_q, 1'b0};
         end
      end
   end

   assign mdioOut = mdioOut_q;
   assign mdioOe  = mdioOe_q;

   // ----------------------------------------------------------------
   // Partner ability register
   // ----------------------------------------------------------------
   always_comb
   begin
      abil_d = abil_q;
      if (pageRxPulse)
         abil_d = pageWord & ~anps_pkg::ABIL_RSVD_MASK;
      if (parDet100Pulse)
         abil_d[anps_pkg::ABIL_TX_BIT] = 1'b1;
      if (parDet10Pulse)
         abil_d[anps_pkg::ABIL_10_BIT] = 1'b1;
   end

   // Bits 15..13, 10..8, 6 and 4..0 come straight from the received word.
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         abil_q <= anps_pkg::ABIL_RESET;
      else
         abil_q <= abil_d;
   end

   // ----------------------------------------------------------------
   // Expansion and history flags
   // ----------------------------------------------------------------
   assign flagSet = {mlfPulse, pageRxPulse,
                     abilityDetectPulse, parallelFaultPulse, linkCheckPulse};
   // Reading the ability register consumes the page-received flag.
   assign flagClr = {1'b0, rdCapture && (regSel_q == anps_pkg::REG_ABIL), 3'h0};

   // ----------------------------------------------------------------
   // Setup register and its outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         setup_q <= anps_pkg::SETUP_RESET;
      else if (wrCommit)
         setup_q <= {wrShift_q[anps_pkg::SETUP_LED_BIT - 1],
                     wrShift_q[anps_pkg::SETUP_FAST_BIT - 1],
                     wrShift_q[anps_pkg::SETUP_LOOP_BIT - 1]};
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
         ledOut_q <= 1'b0;
      else
         ledOut_q <= setup_q[2] ? linkPulse : ledNormal;
   end

   assign fourthStatusLed = ledOut_q;
   assign timerFastMode   = setup_q[1];
   assign autonegLoopback = setup_q[0];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_abilLoad;
      pageRxPulse && !parDet100Pulse && !parDet10Pulse |=>
         abil_q == ($past(pageWord) & ~anps_pkg::ABIL_RSVD_MASK);
   endproperty
   a_abilLoad: assert property (p_abilLoad) else $error("ability word not captured");
   property p_par100;
      parDet100Pulse |=> abil_q[anps_pkg::ABIL_TX_BIT];
   endproperty
   a_par100: assert property (p_par100) else $error("fast ability bit not set");
   property p_par10;
      parDet10Pulse && !pageRxPulse |=> abil_q[anps_pkg::ABIL_10_BIT];
   endproperty
   a_par10: assert property (p_par10) else $error("slow ability bit not set");
   property p_expRsvd;
      (regRead(anps_pkg::REG_EXP) >> 5) == 16'h0000;
   endproperty
   a_expRsvd: assert property (p_expRsvd) else $error("expansion reserved bits set");
   property p_mlf;
      mlfPulse |=> flags[4] [*3];
   endproperty
   a_mlf: assert property (p_mlf) else $error("link fault flag not sticky");
   property p_pageClr;
      rdCapture && (regSel_q == anps_pkg::REG_ABIL) && !pageRxPulse |=> !flags[3];
   endproperty
   a_pageClr: assert property (p_pageClr) else $error("page flag not cleared");
   property p_pageSet;
      pageRxPulse |=> flags[3];
   endproperty
   a_pageSet: assert property (p_pageSet) else $error("page flag not set");
   property p_history;
      ($past(flags[2:0]) & ~flags[2:0]) == 3'h0;
   endproperty
   a_history: assert property (p_history) else $error("history flag dropped");
   property p_led;
      setup_q[2] && linkPulse |=> fourthStatusLed;
   endproperty
   a_led: assert property (p_led) else $error("link pulse not on led");
   property p_setupHold;
      !wrCommit |=> setup_q == $past(setup_q);
   endproperty
   a_setupHold: assert property (p_setupHold) else $error("setup changed without write");
   property p_oeOnRead;
      mdioOe |-> (hit_q && !isWrite_q && (state_q == S_TA || state_q == S_DATA));
   endproperty
   a_oeOnRead: assert property (p_oeOnRead) else $error("mdio driven outside read");

endmodule : anps_regs

// ---- verif/anps_mgmt_model.sv ----
// Station management controller model for the partner-status register group.
// Assumes its tasks are entered at a falling clock edge.
`timescale 1ns/1ps
module anps_mgmt_model #(
   parameter int H = 6
) (
   // Clock
   input  wire logic clock,
   // Management pins
   output logic      mdc,
   output logic      mdioWire,
   input  wire logic mdioOut,
   input  wire logic mdioOe
);
   logic drvEn;
   logic drvVal;
   logic smp;
   // Preamble length of the next frames; after the first frame it may drop to zero.
   int   preLen = 32;

   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // The data line has a pull-up, so a released line reads one.
   assign mdioWire = mdioOe ? mdioOut : (drvEn ? drvVal : 1'b1);

   initial
   begin
      mdc    = 1'b0;
      drvEn  = 1'b0;
      drvVal = 1'b1;
      smp    = 1'b1;
   end

   // ----------------------------------------------------------------
   // Bit and frame tasks
   // ----------------------------------------------------------------
   // Data changes with the clock low and is sampled just before the rise.
   task automatic tick(input logic v, input logic en);
      drvVal = v;
      drvEn  = en;
      repeat (H) @(negedge clock);
      smp = mdioWire;
      mdc = 1'b1;
      repeat (H) @(negedge clock);
      mdc = 1'b0;
   endtask : tick

   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      hdr = {2'h1, op, phy, rg};
      rd  = 16'h0000;
      for (int i = 0; i < preLen; i++) tick(1'b1, 1'b1);
      for (int i = 13; i >= 0; i--) tick(hdr[i], 1'b1);
      if (op == anps_pkg::OP_READ)
      begin
         tick(1'b1, 1'b0);
         tick(1'b1, 1'b0);
         for (int i = 0; i < 16; i++)
         begin
            tick(1'b1, 1'b0);
            rd = {rd[14:0], smp};
         end
      end
      else
      begin
         tick(1'b1, 1'b1);
         tick(1'b0, 1'b1);
         for (int i = 15; i >= 0; i--) tick(wd[i], 1'b1);
      end
      // One released idle bit separates frames.
      tick(1'b1, 1'b0);
   endtask : frame

endmodule : anps_mgmt_model

// ---- verif/tb_anps_regs.sv ----
// Self-checking bench for the partner-status register group.
// Assumes the management model above and a 250 MHz system clock.
`timescale 1ns/1ps
module tb_anps_regs;
   localparam logic [4:0] PHY = 5'h03;

   logic        clock;
   logic        rst_b;
   logic        mdc;
   logic        mdioWire;
   logic        mdioOut;
   logic        mdioOe;
   logic [6:0]  evt;
   logic [15:0] pageWord;
   logic        partnerNpCapable;
   logic        localNpCapable;
   logic        partnerAnCapable;
   logic        linkPulse;
   logic        ledNormal;
   logic        fourthStatusLed;
   logic        timerFastMode;
   logic        autonegLoopback;
   int          miscompares;
   int          checks;

   // ----------------------------------------------------------------
   // Design and controller model
   // ----------------------------------------------------------------
   anps_regs DUT (
      .clock(clock), .rst_b(rst_b), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .phyAddr(PHY), .pageRxPulse(evt[0]), .pageWord(pageWord),
      .parDet100Pulse(evt[1]), .parDet10Pulse(evt[2]), .mlfPulse(evt[3]),
      .partnerNpCapable(partnerNpCapable), .localNpCapable(localNpCapable),
      .partnerAnCapable(partnerAnCapable), .abilityDetectPulse(evt[4]),
      .parallelFaultPulse(evt[5]), .linkCheckPulse(evt[6]), .linkPulse(linkPulse),
      .ledNormal(ledNormal), .fourthStatusLed(fourthStatusLed),
      .timerFastMode(timerFastMode), .autonegLoopback(autonegLoopback)
   );

   anps_mgmt_model M (
      .clock(clock), .mdc(mdc), .mdioWire(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : check

   task automatic rd(input logic [4:0] p, input logic [4:0] a, input logic [15:0] e,
                     input string n);
      logic [15:0] v;
      M.frame(anps_pkg::OP_READ, p, a, 16'h0000, v);
      check(n, v, e);
   endtask : rd

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] v;
      M.frame(anps_pkg::OP_WRITE, PHY, a, d, v);
   endtask : wr

   // Bit order of evt: page, 100 detect, 10 detect, fault, ability, parallel, link check.
   task automatic ev(input int b);
      evt[b] = 1'b1;
      @(negedge clock);
      evt = 7'h00;
      @(negedge clock);
   endtask : ev

   task automatic rst();
      rst_b = 1'b0;
      repeat (5) @(negedge clock);
      rst_b = 1'b1;
   endtask : rst

   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      miscompares = 0;
      checks = 0;
      evt = 7'h00;
      pageWord = 16'h0000;
      {partnerNpCapable, localNpCapable, partnerAnCapable} = 3'h0;
      linkPulse = 1'b0;
      ledNormal = 1'b0;
      rst();
      rd(PHY, anps_pkg::REG_ABIL, 16'h0080, "ability reset");
      rd(PHY, anps_pkg::REG_EXP, 16'h0000, "expansion reset");
      rd(PHY, anps_pkg::REG_SETUP, 16'h0000, "setup reset");
      wr(anps_pkg::REG_ABIL, 16'hFFFF);
      wr(anps_pkg::REG_EXP, 16'hFFFF);
      rd(PHY, anps_pkg::REG_ABIL, 16'h0080, "ability after write");
      rd(PHY, anps_pkg::REG_EXP, 16'h0000, "expansion after write");
      // A foreign address or register must leave the line to its pull-up.
      rd(PHY + 5'h01, anps_pkg::REG_ABIL, 16'hFFFF, "other phy");
      rd(PHY, 5'h00, 16'hFFFF, "unmapped register");
      wr(anps_pkg::REG_SETUP, 16'hFFFF);
      rd(PHY, anps_pkg::REG_SETUP, 16'h0E00, "setup writable");
      check("fast timers", {15'h0000, timerFastMode}, 16'h0001);
      check("loopback", {15'h0000, autonegLoopback}, 16'h0001);
      linkPulse = 1'b1;
      repeat (3) @(negedge clock);
      check("led pulse high", {15'h0000, fourthStatusLed}, 16'h0001);
      linkPulse = 1'b0;
      ledNormal = 1'b1;
      repeat (3) @(negedge clock);
      check("led pulse low", {15'h0000, fourthStatusLed}, 16'h0000);
      wr(anps_pkg::REG_SETUP, 16'h0000);
      repeat (3) @(negedge clock);
      check("led normal", {15'h0000, fourthStatusLed}, 16'h0001);
      check("fast timers off", {15'h0000, timerFastMode}, 16'h0000);
      check("loopback off", {15'h0000, autonegLoopback}, 16'h0000);
      pageWord = 16'hFFFF;
      ev(0);
      rd(PHY, anps_pkg::REG_EXP, 16'h0002, "page flag set");
      rd(PHY, anps_pkg::REG_ABIL, 16'hE7FF, "ability all ones");
      rd(PHY, anps_pkg::REG_EXP, 16'h0000, "page flag cleared");
      pageWord = 16'h4021;
      ev(0);
      rd(PHY, anps_pkg::REG_ABIL, 16'h4021, "next page word");
      pageWord = 16'h0000;
      ev(0);
      ev(1);
      ev(2);
      rd(PHY, anps_pkg::REG_ABIL, 16'h00A0, "parallel detection");
      {partnerNpCapable, localNpCapable, partnerAnCapable} = 3'h7;
      ev(3);
      rd(PHY, anps_pkg::REG_EXP, 16'h001D, "expansion levels");
      {partnerNpCapable, localNpCapable, partnerAnCapable} = 3'h0;
      rd(PHY, anps_pkg::REG_EXP, 16'h0010, "fault sticky");
      ev(4);
      rd(PHY, anps_pkg::REG_SETUP, 16'h0004, "ability detect seen");
      ev(5);
      rd(PHY, anps_pkg::REG_SETUP, 16'h0006, "parallel fault seen");
      ev(6);
      rd(PHY, anps_pkg::REG_SETUP, 16'h0007, "link check seen");
      // Later frames lean on the idle bit alone, with no preamble.
      M.preLen = 0;
      wr(anps_pkg::REG_SETUP, 16'h0000);
      rd(PHY, anps_pkg::REG_SETUP, 16'h0007, "history kept");
      M.preLen = 32;
      rst();
      rd(PHY, anps_pkg::REG_SETUP, 16'h0000, "history after reset");
      rd(PHY, anps_pkg::REG_EXP, 16'h0000, "fault after reset");
      rd(PHY, anps_pkg::REG_ABIL, 16'h0080, "ability after reset");
      complete_run();
   end

   // A full run takes about 20000 cycles; this limit leaves ample margin.
   initial
   begin
      repeat (80000) @(posedge clock);
      miscompares++;
      complete_run();
   end

endmodule : tb_anps_regs
